// ### pkg/fapc_pkg.sv
`default_nettype none
package fapc_pkg;
  // command bytes
  localparam logic [7:0] FAPC_CMD_READ = 8'h00;
  localparam logic [7:0] FAPC_CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] FAPC_CMD_RESET = 8'hff;
  localparam logic [7:0] FAPC_CMD_ERASE_SETUP = 8'h30;
  // status bit positions in the data byte
  localparam int FAPC_POLL_BIT = 7;
  localparam int FAPC_TOGGLE_BIT = 6;
  // bus timing at 20 MHz (50 ns period)
  localparam int FAPC_CLK_NS = 50;
  localparam int FAPC_T_WE_PULSE_NS = 50;
  localparam int FAPC_T_WE_HIGH_NS = 100;
  localparam int FAPC_T_ACC_NS = 120;
  localparam int FAPC_WE_LOW_CYC =
    (FAPC_T_WE_PULSE_NS + FAPC_CLK_NS - 1) / FAPC_CLK_NS;
  localparam int FAPC_WE_HIGH_CYC =
    (FAPC_T_WE_HIGH_NS + FAPC_CLK_NS - 1) / FAPC_CLK_NS;
  localparam int FAPC_RD_CYC = (FAPC_T_ACC_NS + FAPC_CLK_NS - 1) / FAPC_CLK_NS;
  localparam logic [3:0] FAPC_CNT_RST = 4'h0;
  // result codes reported to the user
  localparam logic [1:0] FAPC_RES_OK = 2'h0;
  localparam logic [1:0] FAPC_RES_FAIL = 2'h1;
  localparam logic [1:0] FAPC_RES_ABORT = 2'h2;
  // controller states
  typedef enum logic [3:0] {
    FAPC_IDLE = 4'h0,
    FAPC_WR_LOW = 4'h1,
    FAPC_WR_HIGH = 4'h2,
    FAPC_RD_LOW = 4'h3,
    FAPC_RD_HIGH = 4'h4,
    FAPC_DONE = 4'h5
  } fapc_state_e;
  // operation requested by the user
  typedef enum logic [1:0] {
    FAPC_OP_PROG = 2'h0,
    FAPC_OP_ABORT = 2'h1,
    FAPC_OP_READ = 2'h2
  } fapc_op_e;
endpackage
`default_nettype wire

// ### rtl/fapc_pulse_gen.sv
`default_nettype none
// strobe timer: holds a low phase then a high recovery phase
module fapc_pulse_gen
  import fapc_pkg::*;
#(
  parameter int LOW_CYC = 1, // strobe low cycles
  parameter int HIGH_CYC = 2 // recovery cycles
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset
  input wire logic start_i, // begin a strobe
  output logic low_o, // strobe asserted
  output logic busy_o // strobe or recovery running
);
  logic [3:0] cnt_reg; // remaining cycles
  logic ph_reg; // 1 while in low phase
  // phase counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= FAPC_CNT_RST;
      ph_reg <= 1'b0;
    end else if (start_i && !busy_o) begin
      cnt_reg <= 4'(LOW_CYC);
      ph_reg <= 1'b1;
    end else if (cnt_reg > 4'h1) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else if (ph_reg) begin
      // low done, start recovery
      cnt_reg <= 4'(HIGH_CYC);
      ph_reg <= 1'b0;
    end else begin
      cnt_reg <= FAPC_CNT_RST;
    end
  end
  assign low_o = ph_reg;
  assign busy_o = (cnt_reg != FAPC_CNT_RST);
endmodule
`default_nettype wire

// ### rtl/fapc_host.sv
// Behaviour
// R1: write 40H to enter program setup
// R2: next write strobe is program data
// R3: address latched on strobe falling edge
// R4: data latched, programming starts at rise
// R5: no host control during programming
// R6: done when toggle steady, bits match
// R7: two FFH writes abort pending setup
// R8: after failure, two FFH then command
// R9: toggle bit inverts each read while busy
// R10: toggle valid after second strobe rise
// R11: poll bit complements data bit 7
// R12: erase poll bit reads 0 then 1
// R13: poll valid after second strobe rise
// R14: device powers up read only
// R15: low supply forces read only
// R16: 00H selects array read mode
// R17: host waits for completion before next
// R18: mismatch on completion means failure
`default_nettype none
module fapc_host
  import fapc_pkg::*;
#(
  parameter int ADDR_W = 18 // flash address width
) (
  input wire logic CLK_SYS_I, // system clock 20 MHz
  input wire logic RST_N_I, // async reset, active low
  input wire logic REQ_VALID_I, // user request
  output logic REQ_READY_O, // controller idle
  input wire logic [1:0] REQ_OP_I, // fapc_op_e code
  input wire logic [ADDR_W-1:0] REQ_ADDR_I, // target address
  input wire logic [7:0] REQ_DATA_I, // byte to program
  output logic DONE_O, // one-cycle completion pulse
  output logic [1:0] RESULT_O, // result code
  output logic [7:0] RD_DATA_O, // last byte read
  output logic [ADDR_W-1:0] F_ADDR_O, // flash address pins
  output logic F_CE_N_O, // chip select, low active
  output logic F_OE_N_O, // output strobe, low active
  output logic F_WE_N_O, // write strobe, low active
  output logic [7:0] F_DQ_O, // data out
  output logic F_DQ_OE_O, // data drive enable
  input wire logic [7:0] F_DQ_I // data in
);
  fapc_state_e state_reg; // sequencer state
  fapc_op_e op_reg; // operation in hand
  logic [1:0] step_reg; // write index within sequence
  logic [7:0] data_reg; // byte being programmed
  logic [ADDR_W-1:0] addr_reg; // programmed address
  logic [7:0] prev_rd_reg; // previous status read
  logic have_prev_reg; // a previous read exists
  logic [3:0] rd_cnt_reg; // read access wait
  logic wr_start; // launch a write strobe
  logic we_low, we_busy; // strobe timer outputs

  // command byte for a given write step
  function automatic logic [7:0] cmd_byte(input fapc_op_e op, input logic [1:0] st,
                                          input logic [7:0] d);
    if (op == FAPC_OP_ABORT) cmd_byte = FAPC_CMD_RESET; // R7 R8
    else if (op == FAPC_OP_READ) cmd_byte = FAPC_CMD_READ; // R16
    else if (st == 2'h0) cmd_byte = FAPC_CMD_PROG_SETUP; // R1
    else cmd_byte = d; // R2
  endfunction

  // index of the last write for an operation
  function automatic logic [1:0] last_step(input fapc_op_e op);
    last_step = (op == FAPC_OP_READ) ? 2'h0 : 2'h1;
  endfunction

  fapc_pulse_gen #(
    .LOW_CYC(FAPC_WE_LOW_CYC),
    .HIGH_CYC(FAPC_WE_HIGH_CYC)
  ) u_we (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .start_i(wr_start),
    .low_o(we_low),
    .busy_o(we_busy)
  );

  assign REQ_READY_O = (state_reg == FAPC_IDLE); // R17
  assign wr_start = (state_reg == FAPC_WR_LOW) && !we_busy;

  // main sequencer
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= FAPC_IDLE;
      op_reg <= FAPC_OP_READ;
      step_reg <= 2'h0;
      data_reg <= 8'h00;
      addr_reg <= '0;
      have_prev_reg <= 1'b0;
      prev_rd_reg <= 8'h00;
      rd_cnt_reg <= FAPC_CNT_RST;
      DONE_O <= 1'b0;
      RESULT_O <= FAPC_RES_OK;
      RD_DATA_O <= 8'h00;
    end else begin
      DONE_O <= 1'b0;
      unique case (state_reg)
        FAPC_IDLE: begin
          // take a request only when idle
          if (REQ_VALID_I) begin
            // the spare code falls back to read mode, never a blind program
            op_reg <= (REQ_OP_I == 2'h3) ? FAPC_OP_READ : fapc_op_e'(REQ_OP_I);
            data_reg <= REQ_DATA_I;
            addr_reg <= REQ_ADDR_I;
            step_reg <= 2'h0;
            have_prev_reg <= 1'b0;
            state_reg <= FAPC_WR_LOW;
          end
        end
        FAPC_WR_LOW: begin
          // strobe launched this cycle
          if (wr_start) state_reg <= FAPC_WR_HIGH;
        end
        FAPC_WR_HIGH: begin
          // wait until strobe and recovery finish
          if (!we_busy) begin
            if (step_reg != last_step(op_reg)) begin
              step_reg <= step_reg + 2'h1;
              state_reg <= FAPC_WR_LOW;
            end else if (op_reg == FAPC_OP_PROG) begin
              // device runs alone; host only polls
              state_reg <= FAPC_RD_LOW; // R5 R10 R13
              // one extra cycle: the output strobe pin lags the state by a flop
              rd_cnt_reg <= 4'(FAPC_RD_CYC + 1);
            end else begin
              RESULT_O <= (op_reg == FAPC_OP_ABORT) ? FAPC_RES_ABORT : FAPC_RES_OK;
              state_reg <= FAPC_DONE;
            end
          end
        end
        FAPC_RD_LOW: begin
          // hold output strobe for access time
          if (rd_cnt_reg > 4'h1) begin
            rd_cnt_reg <= rd_cnt_reg - 4'h1;
          end else begin
            prev_rd_reg <= F_DQ_I;
            have_prev_reg <= 1'b1;
            RD_DATA_O <= F_DQ_I;
            state_reg <= FAPC_RD_HIGH;
            // toggle steady across two reads ends the algorithm
            if (have_prev_reg &&
                F_DQ_I[FAPC_TOGGLE_BIT] == prev_rd_reg[FAPC_TOGGLE_BIT]) begin // R6 R9
              // status bits must equal the written ones
              if (F_DQ_I[FAPC_POLL_BIT] == data_reg[FAPC_POLL_BIT] &&
                  F_DQ_I[FAPC_TOGGLE_BIT] == data_reg[FAPC_TOGGLE_BIT]) // R6 R11
                RESULT_O <= FAPC_RES_OK;
              else
                RESULT_O <= FAPC_RES_FAIL; // R18
              state_reg <= FAPC_DONE;
            end
          end
        end
        FAPC_RD_HIGH: begin
          // one idle cycle between polls so each read is distinct
          rd_cnt_reg <= 4'(FAPC_RD_CYC + 1);
          state_reg <= FAPC_RD_LOW;
        end
        FAPC_DONE: begin
          DONE_O <= 1'b1;
          state_reg <= FAPC_IDLE;
        end
        default: state_reg <= FAPC_IDLE;
      endcase
    end
  end

  // pin drive; address changes on the edge the first strobe falls, then held past the last rise
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      F_ADDR_O <= '0;
      F_DQ_O <= 8'h00;
      F_DQ_OE_O <= 1'b0;
    end else begin
      F_ADDR_O <= addr_reg; // R3
      F_DQ_O <= cmd_byte(op_reg, step_reg, data_reg); // R4
      F_DQ_OE_O <= (state_reg == FAPC_WR_LOW) || (state_reg == FAPC_WR_HIGH);
    end
  end

  // strobes from state, write strobe from timer
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      F_CE_N_O <= 1'b1;
      F_OE_N_O <= 1'b1;
    end else begin
      F_CE_N_O <= (state_reg == FAPC_IDLE) || (state_reg == FAPC_DONE);
      F_OE_N_O <= (state_reg != FAPC_RD_LOW);
    end
  end
  assign F_WE_N_O = !we_low;

  // checks
  property p_we_not_with_oe;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I) !F_WE_N_O |-> F_OE_N_O;
  endproperty
  a_we_not_with_oe: assert property (p_we_not_with_oe) // R5
    else $error("write and output strobe low together");
  property p_setup_first;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $fell(F_WE_N_O) && op_reg == FAPC_OP_PROG && step_reg == 2'h0
      |-> F_DQ_O == FAPC_CMD_PROG_SETUP && F_DQ_OE_O;
  endproperty
  a_setup_first: assert property (p_setup_first) // R1
    else $error("program setup byte wrong");
  property p_data_second;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $fell(F_WE_N_O) && op_reg == FAPC_OP_PROG && step_reg == 2'h1
      |-> F_DQ_O == data_reg && F_ADDR_O == addr_reg;
  endproperty
  a_data_second: assert property (p_data_second) // R2 R3 R4
    else $error("program data cycle wrong");
  property p_abort_ff;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $fell(F_WE_N_O) && op_reg == FAPC_OP_ABORT |-> F_DQ_O == FAPC_CMD_RESET;
  endproperty
  a_abort_ff: assert property (p_abort_ff) // R7 R8
    else $error("abort byte not FFH");
  property p_read_cmd;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      $fell(F_WE_N_O) && op_reg == FAPC_OP_READ |-> F_DQ_O == FAPC_CMD_READ;
  endproperty
  a_read_cmd: assert property (p_read_cmd) // R16
    else $error("read command not 00H");
  property p_busy_no_req;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (state_reg == FAPC_RD_LOW || state_reg == FAPC_RD_HIGH) |-> F_WE_N_O;
  endproperty
  a_busy_no_req: assert property (p_busy_no_req) // R17
    else $error("write strobe during status polling");
  property p_done_pulse;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I) DONE_O |=> !DONE_O && REQ_READY_O;
  endproperty
  a_done_pulse: assert property (p_done_pulse) // R6
    else $error("done not a single pulse");
  property p_fail_mismatch;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      DONE_O && op_reg == FAPC_OP_PROG && RESULT_O == FAPC_RES_OK
      |-> RD_DATA_O[7:6] == data_reg[7:6];
  endproperty
  a_fail_mismatch: assert property (p_fail_mismatch) // R18
    else $error("ok result with mismatching bits");
  property p_we_width;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I) $fell(F_WE_N_O) |=> $rose(F_WE_N_O);
  endproperty
  a_we_width: assert property (p_we_width) // R4
    else $error("write strobe width wrong");
  c_prog: cover property (@(posedge CLK_SYS_I) DONE_O && op_reg == FAPC_OP_PROG);
  c_fail: cover property (@(posedge CLK_SYS_I) DONE_O && RESULT_O == FAPC_RES_FAIL);
  c_abort: cover property (@(posedge CLK_SYS_I) DONE_O && op_reg == FAPC_OP_ABORT);
endmodule
`default_nettype wire

// ### dv/fapc_flash_model.sv
`default_nettype none
// behavioural byte-wide flash: command register, auto program, status bits
module fapc_flash_model
  import fapc_pkg::*;
#(
  parameter int ADDR_W = 18 // address width
) (
  input wire logic [ADDR_W-1:0] addr_i, // address pins
  input wire logic ce_n_i, // chip select, low active
  input wire logic oe_n_i, // output strobe, low active
  input wire logic we_n_i, // write strobe, low active
  input wire logic [7:0] dq_i, // resolved data bus
  input wire logic fail_i, // corrupt bit 6 of the next program
  input wire logic [3:0] busy_len_i, // status reads while programming
  output logic [7:0] dq_o // read data driven while selected and output enabled
);
  localparam logic [2:0] M_READ = 3'h0;
  localparam logic [2:0] M_SETUP = 3'h1;
  localparam logic [2:0] M_ABT = 3'h2;
  localparam logic [2:0] M_FAIL = 3'h3;
  localparam logic [2:0] M_ESET = 3'h4;
  logic [7:0] mem [256]; // only the low address byte is kept, to stay small
  logic [2:0] mode = M_READ; // powers up read only
  logic [7:0] cmd_reg = 8'h00; // default command is array read
  logic [ADDR_W-1:0] wa = '0; // address latched at strobe fall
  logic [7:0] wd = 8'h00; // byte latched at strobe rise
  logic [7:0] last_d = 8'h00; // byte being programmed
  logic [7:0] log_prev = 8'h00; // second to last written byte
  logic [7:0] log_last = 8'h00; // last written byte
  logic [3:0] busy_cnt = 4'h0; // status reads left before completion
  logic tog = 1'b0; // toggle status bit
  logic erasing = 1'b0; // busy time belongs to an erase
  logic [7:0] last_q = 8'h00; // last byte put on the bus
  logic [7:0] rd_val; // byte a read returns now
  int n_wr = 0; // writes seen
  // erased array
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
  end
  // status while busy, array data after completion
  assign rd_val = (busy_cnt == 4'h0) ? mem[wa[7:0]] :
                  erasing ? {1'b0, tog, 6'h00} :
                  {~last_d[7], tog, last_d[5:0]};
  // released bus shows the inverse so a stale value cannot pass
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd_val : ~last_q;
  // address capture on strobe fall
  always @(negedge we_n_i) begin
    if (!ce_n_i) wa = addr_i;
  end
  // command and data on strobe rise; writes while busy are ignored
  always @(posedge we_n_i) begin
    if (!ce_n_i && busy_cnt == 4'h0) begin
      wd = dq_i;
      n_wr++;
      log_prev = log_last;
      log_last = wd;
      case (mode)
        M_SETUP: begin
          if (wd == 8'hff) begin
            mode = M_ABT;
          end else begin
            mem[wa[7:0]] = fail_i ? (wd ^ 8'h40) : wd;
            last_d = wd;
            busy_cnt = busy_len_i;
            mode = fail_i ? M_FAIL : M_READ;
          end
        end
        M_ESET: begin
          // second erase byte starts the erase; anything else drops it
          if (wd == FAPC_CMD_ERASE_SETUP) begin
            foreach (mem[i]) mem[i] = 8'hff;
            erasing = 1'b1;
            busy_cnt = busy_len_i;
            mode = M_READ;
          end else begin
            mode = (wd == 8'hff) ? M_ABT : M_READ;
          end
        end
        M_ABT: begin
          mode = M_READ;
          cmd_reg = 8'h00;
        end
        M_FAIL: begin
          if (wd == 8'hff) mode = M_ABT;
        end
        default: begin
          cmd_reg = wd;
          if (wd == 8'h40) mode = M_SETUP;
          else if (wd == 8'hff) mode = M_ABT;
          else if (wd == FAPC_CMD_ERASE_SETUP) mode = M_ESET;
        end
      endcase
    end
  end
  // each read while busy flips the toggle bit
  always @(negedge oe_n_i) begin
    if (!ce_n_i && busy_cnt != 4'h0) tog = ~tog;
  end
  // a read ends: remember the byte, count down the algorithm
  always @(posedge oe_n_i) begin
    if (!ce_n_i) begin
      last_q = rd_val;
      if (busy_cnt != 4'h0) busy_cnt--;
      if (busy_cnt == 4'h0) erasing = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fapc_pkg::*;
  logic CLK_SYS_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic REQ_VALID_I = 1'b0;
  logic [1:0] REQ_OP_I = 2'h0;
  logic [17:0] REQ_ADDR_I = 18'h00000;
  logic [7:0] REQ_DATA_I = 8'h00;
  logic REQ_READY_O, DONE_O, F_CE_N_O, F_OE_N_O, F_WE_N_O, F_DQ_OE_O;
  logic [1:0] RESULT_O;
  logic [7:0] RD_DATA_O, F_DQ_O, F_DQ_I, fl_q;
  logic [17:0] F_ADDR_O;
  logic fl_fail = 1'b0; // device corrupts the next program
  logic [3:0] fl_busy = 4'h0; // device busy length in reads
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  fapc_host dut (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .REQ_VALID_I(REQ_VALID_I),
    .REQ_READY_O(REQ_READY_O), .REQ_OP_I(REQ_OP_I), .REQ_ADDR_I(REQ_ADDR_I),
    .REQ_DATA_I(REQ_DATA_I), .DONE_O(DONE_O), .RESULT_O(RESULT_O), .RD_DATA_O(RD_DATA_O),
    .F_ADDR_O(F_ADDR_O), .F_CE_N_O(F_CE_N_O), .F_OE_N_O(F_OE_N_O), .F_WE_N_O(F_WE_N_O),
    .F_DQ_O(F_DQ_O), .F_DQ_OE_O(F_DQ_OE_O), .F_DQ_I(F_DQ_I));
  fapc_flash_model fl (.addr_i(F_ADDR_O), .ce_n_i(F_CE_N_O), .oe_n_i(F_OE_N_O),
    .we_n_i(F_WE_N_O), .dq_i(F_DQ_I), .fail_i(fl_fail), .busy_len_i(fl_busy), .dq_o(fl_q));
  // resolved data bus seen by both parties
  assign F_DQ_I = F_DQ_OE_O ? F_DQ_O : fl_q;
  // 20 MHz clock
  initial begin
    forever #25 CLK_SYS_I = ~CLK_SYS_I;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one request, then a bounded wait for the completion pulse
  task automatic run_op(input logic [1:0] op, input logic [17:0] a, input logic [7:0] d,
                        input logic [3:0] bl, input logic f);
    int k;
    @(posedge CLK_SYS_I);
    REQ_OP_I <= op;
    REQ_ADDR_I <= a;
    REQ_DATA_I <= d;
    fl_busy <= bl;
    fl_fail <= f;
    REQ_VALID_I <= 1'b1;
    @(posedge CLK_SYS_I);
    REQ_VALID_I <= 1'b0;
    for (k = 0; k < 3000; k++) begin
      #1;
      if (DONE_O === 1'b1) break;
      @(posedge CLK_SYS_I);
    end
    chk({7'h00, DONE_O}, 8'h01);
  endtask
  // back-to-back programs over both bit 7 values and short and long busy times
  task automatic t_prog();
    logic [7:0] dt [4] = '{8'ha5, 8'h3c, 8'h80, 8'h7f};
    logic [3:0] bl [4] = '{4'h3, 4'hc, 4'h1, 4'h0};
    for (int i = 0; i < 4; i++) begin
      run_op(2'(FAPC_OP_PROG), 18'h00010 + 18'(i), dt[i], bl[i], 1'b0);
      chk({6'h00, RESULT_O}, {6'h00, FAPC_RES_OK});
      chk(fl.log_prev, 8'h40);
      chk(fl.log_last, dt[i]);
      chk(fl.wa[7:0], 8'h10 + 8'(i));
      chk(fl.mem[8'h10 + 8'(i)], dt[i]);
      chk(RD_DATA_O, dt[i]);
    end
  endtask
  // failed program, then recovery by the reset pair and a fresh program
  task automatic t_fail();
    run_op(2'(FAPC_OP_PROG), 18'h00040, 8'h5a, 4'h4, 1'b1);
    chk({6'h00, RESULT_O}, {6'h00, FAPC_RES_FAIL});
    chk({5'h00, fl.mode}, 8'h03);
    run_op(2'(FAPC_OP_ABORT), 18'h00000, 8'h00, 4'h0, 1'b0);
    chk({6'h00, RESULT_O}, {6'h00, FAPC_RES_ABORT});
    chk({5'h00, fl.mode}, 8'h00);
    chk(fl.mem[8'h40], 8'h1a);
    run_op(2'(FAPC_OP_PROG), 18'h00041, 8'h66, 4'h2, 1'b0);
    chk({6'h00, RESULT_O}, {6'h00, FAPC_RES_OK});
  endtask
  // reset pair from read mode writes two FFH and leaves the byte at 10H as programmed
  task automatic t_abort();
    int w0;
    w0 = fl.n_wr;
    run_op(2'(FAPC_OP_ABORT), 18'h00010, 8'h00, 4'h0, 1'b0);
    chk(8'(fl.n_wr - w0), 8'h02);
    chk(fl.log_prev, 8'hff);
    chk(fl.log_last, 8'hff);
    chk(fl.mem[8'h10], 8'ha5);
  endtask
  // read command writes 00H
  task automatic t_read();
    run_op(2'(FAPC_OP_READ), 18'h00000, 8'h00, 4'h0, 1'b0);
    chk(fl.log_last, FAPC_CMD_READ);
    chk(fl.cmd_reg, 8'h00);
  endtask
  // host must not drive the bus while the device is output enabled
  always @(posedge CLK_SYS_I) begin
    if (RST_N_I && !F_OE_N_O) chk({7'h00, F_DQ_OE_O}, 8'h00);
  end
  // hang guard
  always @(posedge CLK_SYS_I) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge CLK_SYS_I);
    RST_N_I <= 1'b1;
    chk({7'h00, REQ_READY_O}, 8'h01);
    chk({5'h00, fl.mode}, 8'h00);
    chk(fl.cmd_reg, FAPC_CMD_READ);
    t_prog();
    t_fail();
    t_abort();
    t_read();
    close_out();
  end
endmodule
`default_nettype wire
